/* adc_ctrl_pkg.sv */
// Package with register map, field layout and timing constants of the converter control block.
package adc_ctrl_pkg;

	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_RESULT_LOW = 8'h04;
	localparam logic [7:0] OFF_RESULT_HIGH = 8'h08;
	localparam logic [7:0] OFF_CLOCK_SEL = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

	// ==========================================
	// Control register field positions
	localparam int CH_LSB = 0;
	localparam int PCFG_LSB = 3;
	localparam int PEND_BIT = 6;
	localparam int START_BIT = 7;

	// ==========================================
	// Reset values
	localparam logic [2:0] CH_RESET = 3'h0;
	localparam logic [2:0] PCFG_RESET = 3'h0;
	localparam logic [2:0] CLKSEL_RESET = 3'h0;
	localparam logic PEND_RESET = 1'b1;

	// ==========================================
	// Timing: converter clock periods per conversion cycle
	localparam logic [4:0] CONV_PERIODS = 5'h10;
	localparam int NUM_CH = 8;

	// Sequencer states.
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_HOLD = 3'b010,
		S_CONV = 3'b100
	} conv_state_t;

	// Link to the analog core.
	typedef struct packed {
		logic [2:0] channel;
		logic power_on;
		logic core_reset;
		logic sample_clk;
	} core_ctrl_t;

endpackage

/* adc_conversion_control.sv */
// Converter control, result registers and APB slave of the analog-to-digital unit.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Eight analog input pins; three-bit channel select routes one to the converter.
// - High result register holds result bits 11 to 4 in bits 7 to 0.
// - Low result register holds result bits 3 to 0 in bits 7 to 4.
// - Three-bit pin configuration field picks which pins are analog inputs.
// - All-zero pin configuration keeps pins digital and powers the converter off.
// - A complete low-high-low start pulse begins one conversion cycle.
// - While start is high, converter held in reset and pending flag forced high.
// - Pending flag clears by itself when a conversion cycle finishes.
// - Completion sets the interrupt request flag; enabled, it raises the interrupt.
// - Converter clock is the system clock divided by a three-bit selected ratio.
// - Analog-enabled pins override port direction and drop the pull-high resistor.
module adc_conversion_control
	import adc_ctrl_pkg::*;
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic ARST_N,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Analog core.
	output core_ctrl_t CORE,
	input wire logic [11:0] CORE_RESULT,
	// Pin function control.
	output logic [7:0] ANALOG_PIN_EN,
	output logic [7:0] DIR_OVERRIDE,
	output logic [7:0] PULLUP_DISABLE,
	// Interrupt.
	output logic IRQ
);

	// ==========================================
	// Registers
	logic [2:0] channel_select;
	logic [2:0] analog_pin_config;
	logic [2:0] conv_clock_select;
	logic start;
	logic conversion_pending_flag;
	logic [11:0] result_bits;
	logic irq_status;
	logic irq_mask;
	logic [2:0] div_cnt;
	logic conv_tick;
	logic sample_clk;
	logic [4:0] period_cnt;
	conv_state_t state;
	conv_state_t next_state;
	logic [11:0] core_sync1;
	logic [11:0] core_sync2;

	// ==========================================
	// Bus decode
	wire bus_write = PSEL && PENABLE && PWRITE;
	wire wr_ctrl = bus_write && (PADDR == OFF_CONTROL);
	wire wr_clk = bus_write && (PADDR == OFF_CLOCK_SEL);
	wire wr_stat = bus_write && (PADDR == OFF_IRQ_STATUS);
	wire wr_mask = bus_write && (PADDR == OFF_IRQ_MASK);
	wire hit = (PADDR == OFF_CONTROL) || (PADDR == OFF_RESULT_LOW) ||
		(PADDR == OFF_RESULT_HIGH) || (PADDR == OFF_CLOCK_SEL) ||
		(PADDR == OFF_IRQ_STATUS) || (PADDR == OFF_IRQ_MASK);
	wire next_start = wr_ctrl ? PWDATA[START_BIT] : start;
	wire start_fall = start && !next_start;
	wire done = (state == S_CONV) && conv_tick && (period_cnt == CONV_PERIODS - 5'h01);
	wire [7:0] ctrl_rd = {start, conversion_pending_flag, analog_pin_config, channel_select};

	// Slave answers in the first access cycle; unmapped addresses error.
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit;

	// Read data multiplexer.
	always_comb begin
		case (PADDR)
			OFF_CONTROL: PRDATA = {24'h000000, ctrl_rd};
			OFF_RESULT_LOW: PRDATA = {24'h000000, result_bits[3:0], 4'h0};
			OFF_RESULT_HIGH: PRDATA = {24'h000000, result_bits[11:4]};
			OFF_CLOCK_SEL: PRDATA = {29'h00000000, conv_clock_select};
			OFF_IRQ_STATUS: PRDATA = {31'h00000000, irq_status};
			OFF_IRQ_MASK: PRDATA = {31'h00000000, irq_mask};
			default: PRDATA = 32'h00000000;
		endcase
	end

	// Control fields written by software.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			channel_select <= CH_RESET;
			analog_pin_config <= PCFG_RESET;
			start <= 1'b0;
			conv_clock_select <= CLKSEL_RESET;
			irq_mask <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				channel_select <= PWDATA[CH_LSB +: 3];
				analog_pin_config <= PWDATA[PCFG_LSB +: 3];
			end
			start <= next_start;
			if (wr_clk)
				conv_clock_select <= PWDATA[2:0];
			if (wr_mask)
				irq_mask <= PWDATA[0];
		end
	end

	// Converter clock divider: ratio is twice (select plus one) system clocks.
	// It is held at its start while the start bit is high, so that a conversion
	// always begins on a whole converter period and lasts exactly sixteen of them.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_cnt <= 3'h0;
			sample_clk <= 1'b0;
		end else if (start) begin
			div_cnt <= 3'h0;
			sample_clk <= 1'b0;
		end else if (div_cnt == conv_clock_select) begin
			div_cnt <= 3'h0;
			sample_clk <= !sample_clk;
		end else begin
			div_cnt <= div_cnt + 3'h1;
		end
	end
	assign conv_tick = (div_cnt == conv_clock_select) && sample_clk;

	// Sequencer next state.
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE, S_HOLD: begin
				if (start_fall) next_state = S_CONV;
				else if (start) next_state = S_HOLD;
			end
			S_CONV: begin
				if (start) next_state = S_HOLD;
				else if (done) next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
	end

	// Sequencer, period counter, pending flag and result capture.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= S_IDLE;
			period_cnt <= 5'h00;
			conversion_pending_flag <= PEND_RESET;
			result_bits <= 12'h000;
		end else begin
			state <= next_state;
			if (state != S_CONV)
				period_cnt <= 5'h00;
			else if (conv_tick)
				period_cnt <= period_cnt + 5'h01;
			if (start)
				conversion_pending_flag <= 1'b1;
			else if (done) begin
				conversion_pending_flag <= 1'b0;
				result_bits <= core_sync2;
			end
		end
	end

	// Result word from the analog core crosses through two flip-flops.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			core_sync1 <= 12'h000;
			core_sync2 <= 12'h000;
		end else begin
			core_sync1 <= CORE_RESULT;
			core_sync2 <= core_sync1;
		end
	end

	// Interrupt status: completion sets, write-one clears, set wins.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			irq_status <= 1'b0;
		else if (done && !start)
			irq_status <= 1'b1;
		else if (wr_stat && PWDATA[0])
			irq_status <= 1'b0;
	end
	assign IRQ = irq_status && irq_mask;

	// Core control outputs.
	assign CORE = {channel_select, (analog_pin_config != 3'h0),
		start || (state != S_CONV), sample_clk};

	// Pin function decode: nonzero config N enables analog on pins 0..N; config 0 enables none.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_pin
			assign ANALOG_PIN_EN[gi] = (analog_pin_config != 3'h0) &&
				(gi <= int'(analog_pin_config));
			assign DIR_OVERRIDE[gi] = ANALOG_PIN_EN[gi];
			assign PULLUP_DISABLE[gi] = ANALOG_PIN_EN[gi];
		end
	endgenerate

	// ==========================================
	// Assertions
	a_hold_pending: assert property (@(posedge CLK) disable iff (!ARST_N)
		start |=> conversion_pending_flag) else $error("pending flag low during start");
	a_hold_reset: assert property (@(posedge CLK) disable iff (!ARST_N)
		start |-> CORE.core_reset) else $error("core not in reset during start");
	a_fall_starts: assert property (@(posedge CLK) disable iff (!ARST_N)
		$fell(start) |-> state == S_CONV) else $error("no conversion after start pulse");
	a_done_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
		(done && !start) |=> !conversion_pending_flag && irq_status) else $error("done lost");
	a_irq_level: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ == (irq_status && irq_mask)) else $error("irq mismatch");
	a_power_off: assert property (@(posedge CLK) disable iff (!ARST_N)
		(analog_pin_config == 3'h0) |-> (ANALOG_PIN_EN == 8'h00) && !CORE.power_on)
		else $error("pins analog while off");
	a_pin_override: assert property (@(posedge CLK) disable iff (!ARST_N)
		(DIR_OVERRIDE == ANALOG_PIN_EN) && (PULLUP_DISABLE == ANALOG_PIN_EN))
		else $error("override mismatch");
	a_result_map: assert property (@(posedge CLK) disable iff (!ARST_N)
		(PADDR == OFF_RESULT_LOW) |-> PRDATA[3:0] == 4'h0) else $error("low nibble set");
	a_conv_length: assert property (@(posedge CLK) disable iff (!ARST_N)
		done |-> period_cnt == 5'h0F) else $error("wrong conversion length");

	// ==========================================
	// Sequencer and divider checks
	// A start pulse only one clock long must still launch a conversion, so the
	// idle state watches for the falling start bit as well as the hold state.
	// The divider restarts while start is high; a conversion therefore never
	// inherits a part-spent converter period from before the pulse.

	// Converter ticks never come on two neighbouring clocks.
	a_tick_spacing: assert property (@(posedge CLK) disable iff (!ARST_N)
		conv_tick |=> !conv_tick)
		else $error("converter ticks too close");

	// The divider sits at its start while the start bit is high.
	a_divider_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		start |=> (div_cnt == 3'h0) && !sample_clk)
		else $error("divider running during start");

	// Raising start during a conversion aborts it into the hold state.
	a_abort_conv: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == S_CONV) && start |=> state == S_HOLD)
		else $error("conversion not aborted by start");

	// A running conversion keeps going until it is done or aborted.
	a_conv_stays: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == S_CONV) && !start && !done |=> state == S_CONV)
		else $error("conversion ended early");

	// A finished conversion returns the sequencer to idle.
	a_done_idle: assert property (@(posedge CLK) disable iff (!ARST_N)
		(done && !start) |=> state == S_IDLE)
		else $error("sequencer not idle after completion");

	// The pending flag stays high while a conversion is in progress.
	a_pend_busy: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == S_CONV) && !done |=> conversion_pending_flag)
		else $error("pending flag low during conversion");

	// Outside a conversion the core is held in reset.
	a_idle_reset: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state != S_CONV) |-> CORE.core_reset)
		else $error("core out of reset while not converting");

	// The result registers change only when a conversion completes.
	a_result_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		!done |=> $stable(result_bits))
		else $error("result changed without completion");

	// A write of one clears the status bit when no completion competes.
	a_irq_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
		(wr_stat && PWDATA[0] && !(done && !start)) |=> !irq_status)
		else $error("status bit not cleared");

	// The status bit is sticky until software clears it.
	a_stat_sticky: assert property (@(posedge CLK) disable iff (!ARST_N)
		irq_status && !(wr_stat && PWDATA[0]) |=> irq_status)
		else $error("status bit lost");

	// Any nonzero pin configuration powers the core and claims pin zero.
	a_power_on: assert property (@(posedge CLK) disable iff (!ARST_N)
		(analog_pin_config != 3'h0) |-> CORE.power_on && ANALOG_PIN_EN[0])
		else $error("converter not powered");

	// A control write routes the newly chosen channel to the core.
	a_channel_route: assert property (@(posedge CLK) disable iff (!ARST_N)
		wr_ctrl |=> CORE.channel == $past(PWDATA[2:0]))
		else $error("channel not routed");

	// An idle sequencer without start never jumps into a conversion.
	a_start_order: assert property (@(posedge CLK) disable iff (!ARST_N)
		(state == S_IDLE) && !start |=> state != S_CONV)
		else $error("conversion without start pulse");

endmodule

`default_nettype wire

/* adc_core_model.sv */
// Behavioural model of the analog converter core and its input level.
`timescale 1ns/1ns
`default_nettype none
module adc_core_model
	import adc_ctrl_pkg::*;
(
	// Clock.
	input wire logic CLK,
	// Link from the control block.
	input wire core_ctrl_t CORE,
	input wire logic [11:0] LEVEL,
	// Digitised value.
	output logic [11:0] CORE_RESULT
);
	// ==========================================
	// Conversion value
	// A powered-off core drives a changing pattern, never a held value.
	always @(posedge CLK) begin
		if (!CORE.power_on) begin
			CORE_RESULT <= ~CORE_RESULT;
		end else begin
			CORE_RESULT <= LEVEL ^ {9'h000, CORE.channel};
		end
	end
endmodule
`default_nettype wire

/* tb_adc_conversion_control.sv */
// Self-checking bench of the converter control block.
`timescale 1ns/1ns
`default_nettype none
module tb_adc_conversion_control
	import adc_ctrl_pkg::*;
;
	logic CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, IRQ;
	logic [7:0] PADDR = 8'h00, ANALOG_PIN_EN, DIR_OVERRIDE, PULLUP_DISABLE, m;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic [11:0] CORE_RESULT, LEVEL = 12'h000, v;
	logic [2:0] sel;
	logic [32:0] exp_q[$];
	core_ctrl_t CORE;
	int n_fail = 0, total_checks = 0, seed = 47459, n;

	// Clock at 20 MHz.
	always #25 CLK = ~CLK;

	adc_conversion_control adc_conversion_control_i (.CLK(CLK), .ARST_N(ARST_N),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE(CORE),
		.CORE_RESULT(CORE_RESULT), .ANALOG_PIN_EN(ANALOG_PIN_EN),
		.DIR_OVERRIDE(DIR_OVERRIDE), .PULLUP_DISABLE(PULLUP_DISABLE), .IRQ(IRQ));
	adc_core_model adc_core_model_i (.CLK(CLK), .CORE(CORE), .LEVEL(LEVEL),
		.CORE_RESULT(CORE_RESULT));

	// ==========================================
	// Helpers
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Notes the expected error flag and data, then reads.
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Compares each completed read with the oldest note.
	always @(posedge CLK) begin
		if (PSEL && PENABLE && PREADY && !PWRITE) begin
			chk({PSLVERR, PRDATA}, exp_q.pop_front());
		end
	end

	// Cuts a hang short.
	initial begin
		#1000000;
		n_fail++;
		final_report;
	end

	// ==========================================
	// Tests
	initial begin
		repeat (2) @(posedge CLK);
		ARST_N <= 1'b1;
		rd(OFF_CONTROL, {26'h0, PEND_RESET, 6'h00});
		rd(8'h18, {1'b1, 32'h0});
		rd(OFF_IRQ_STATUS, 33'h0);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			wr(OFF_CONTROL, {26'h0, i[2:0], 3'h0});
			@(negedge CLK);
			m = (i == 0) ? 8'h00 : 8'((9'h002 << i) - 9'h001);
			chk({8'h0, ANALOG_PIN_EN, DIR_OVERRIDE, PULLUP_DISABLE, CORE.power_on},
				{8'h0, m, m, m, i != 0});
		end
		$display("pin test done");
		for (int c = 0; c < 8; c++) begin
			sel = 3'($random(seed));
			LEVEL <= 12'($random(seed));
			wr(OFF_CLOCK_SEL, {29'h0, sel});
			wr(OFF_IRQ_MASK, {31'h0, c[0]});
			wr(OFF_CONTROL, {24'h0, 2'b10, 3'h7, c[2:0]});
			@(negedge CLK);
			chk({32'h0, CORE.core_reset}, 33'h1);
			rd(OFF_CONTROL, {25'h0, 2'b11, 3'h7, c[2:0]});
			wr(OFF_CONTROL, {24'h0, 2'b00, 3'h7, c[2:0]});
			@(negedge CLK);
			n = 0;
			while (CORE.core_reset !== 1'b1 && n < 2000) begin
				@(negedge CLK);
				n++;
			end
			chk({32'h0, n >= 32 * (sel + 1) - 2 && n <= 32 * (sel + 1) + 3}, 33'h1);
			repeat (2) @(negedge CLK);
			chk({32'h0, IRQ}, {32'h0, c[0]});
			v = LEVEL ^ {9'h000, c[2:0]};
			rd(OFF_CONTROL, {25'h0, 2'b00, 3'h7, c[2:0]});
			rd(OFF_RESULT_HIGH, {25'h0, v[11:4]});
			rd(OFF_RESULT_LOW, {25'h0, v[3:0], 4'h0});
			rd(OFF_IRQ_STATUS, 33'h1);
			wr(OFF_IRQ_STATUS, 32'h1);
			rd(OFF_IRQ_STATUS, 33'h0);
		end
		$display("conversion test done");
		final_report;
	end
endmodule
`default_nettype wire
